// *** pkg/acg_pkg.sv ***
// Constants and carrier types for the converter control block.
// Assumes one 20 MHz clock domain; the modulator and filter sit outside.
package acg_pkg;
    localparam int unsigned DATA_W       = 16;
    localparam int unsigned CFG_REGS     = 4;
    localparam int unsigned CNT_W        = 24;
    localparam int unsigned CLK_HZ       = 20000000;
    localparam int unsigned BASE_RATE_HZ = 20;
    localparam int unsigned BASE_CYCLES  = CLK_HZ / BASE_RATE_HZ;

    // Command bytes; low bits carry a register index where used
    localparam logic [7:0] CMD_RESET     = 8'h06;
    localparam logic [7:0] CMD_START     = 8'h08;
    localparam logic [7:0] CMD_POWERDOWN = 8'h02;
    localparam logic [7:0] CMD_RDATA     = 8'h10;
    localparam logic [7:0] CMD_RREG      = 8'h20;
    localparam logic [7:0] CMD_WREG      = 8'h40;
    localparam logic [7:0] CMD_REG_MASK  = 8'hF0;
    localparam int unsigned CMD_IDX_LSB  = 2;

    // Field layout: register 0 and register 1
    localparam int unsigned SKIP_BIT     = 0;
    localparam int unsigned GAIN_LSB     = 1;
    localparam int unsigned MUX_LSB      = 4;
    localparam int unsigned MODE_BIT     = 3;
    localparam int unsigned RATE_LSB     = 5;
    localparam logic [3:0] MUX_GND_LO    = 4'h8;
    localparam logic [3:0] MUX_GND_HI    = 4'hB;
    localparam logic [2:0] GAIN_SC_MAX   = 3'h2;
    localparam logic [7:0] CFG_RST       = 8'h00;

    // Full-scale span in microvolts at gain 1 with the internal reference
    localparam logic [21:0] FSR_UV_G1    = 22'h1F4000;

    typedef struct packed {
        logic [2:0]  amp_log2;
        logic [1:0]  sc_log2;
        logic        amp_on;
        logic [21:0] full_scale_span;
    } acg_gain_t;

    typedef struct packed {
        logic [7:0] byte_val;
        logic       valid;
    } acg_cmd_t;
endpackage : acg_pkg

// *** rtl/acg_cmd_rx.sv ***
// Two-wire command byte receiver.
// Assumes raw pins; both are synchronised before use. Address bytes are not filtered.
`timescale 1ns/1ps
module acg_cmd_rx (
    input  wire logic      ref_clk,
    input  wire logic      resetn,
    input  wire logic      scl_i,
    input  wire logic      sda_i,
    output logic           sda_o,
    output logic           sda_oe_n,
    output acg_pkg::acg_cmd_t cmd
);
    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic       scl_p;
        logic       sda_p;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        acg_pkg::acg_cmd_t cmd;
        logic       ack;
    } acg_rx_t;

    acg_rx_t st_r;
    acg_rx_t st_nxt;
    logic    rise;
    logic    fall;

    assign rise = st_r.scl_s[1] & ~st_r.scl_p;
    assign fall = ~st_r.scl_s[1] & st_r.scl_p;

    always_comb begin
        st_nxt           = st_r;
        st_nxt.scl_s     = {st_r.scl_s[0], scl_i};
        st_nxt.sda_s     = {st_r.sda_s[0], sda_i};
        st_nxt.scl_p     = st_r.scl_s[1];
        st_nxt.sda_p     = st_r.sda_s[1];
        st_nxt.cmd.valid = 1'b0;
        if (st_r.scl_s[1] && st_r.sda_p && !st_r.sda_s[1]) begin
            st_nxt.bit_cnt = 4'h0;
            st_nxt.ack     = 1'b0;
        end else if (rise && st_r.bit_cnt < 4'h8) begin
            // Count sampled bits, so the fall that follows START is not taken as one
            st_nxt.shift   = {st_r.shift[6:0], st_r.sda_s[1]};
            st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
        end else if (fall) begin
            if (st_r.bit_cnt == 4'h8 && !st_r.ack) begin
                st_nxt.cmd.byte_val = st_r.shift;
                st_nxt.cmd.valid    = 1'b1;
                st_nxt.ack          = 1'b1;
            end else if (st_r.ack) begin
                st_nxt.bit_cnt = 4'h0;
                st_nxt.ack     = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st_r <= '{scl_s: 2'h3, sda_s: 2'h3, scl_p: 1'b1, sda_p: 1'b1, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cmd      = st_r.cmd;
    assign sda_o    = 1'b0;
    assign sda_oe_n = ~st_r.ack;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    AST_LATCH_EIGHTH: assert property (st_nxt.cmd.valid |-> fall && st_r.bit_cnt == 4'h8)
        else $error("Byte latched off the eighth falling edge");
    AST_ACK_AFTER: assert property (st_r.cmd.valid |-> !sda_oe_n)
        else $error("No acknowledge after latched byte");
endmodule : acg_cmd_rx

// *** rtl/acg_conv_ctrl.sv ***
// Conversion sequencing, result buffer and gain decode of the converter.
// Assumes filter data in the ref_clk domain, valid whenever a conversion ends.
// How it works
// - Single-shot: one conversion per start, buffered.
// - Single-shot ends in low-power idle.
// - Continuous: next conversion starts at once.
// - Continuous results come at programmed rate.
// - Reads return latest result, never torn.
// - Four configuration registers, six commands.
// - Three-bit gain selects one of eight.
// - Gain split between amplifier and capacitor stage.
// - Gains 1, 2, 4 use capacitor stage only.
// - Full-scale span is reference over gain.
// - Skip bit bypasses amplifier at gains <=4.
// - Ground-referenced inputs force bypass, clamp gain.
// - Command byte latched on eighth falling edge.
`timescale 1ns/1ps
module acg_conv_ctrl #(
    parameter int unsigned BASE_CYCLES = acg_pkg::BASE_CYCLES
) (
    input  wire logic               ref_clk,
    input  wire logic               resetn,
    input  wire logic               scl_i,
    input  wire logic               sda_i,
    output logic                    sda_o,
    output logic                    sda_oe_n,
    input  wire logic [15:0]        conv_data_in,
    output logic [15:0]             rd_data,
    output logic                    drdy_n,
    output logic                    low_power,
    output logic [3:0]              input_select_field,
    output acg_pkg::acg_gain_t      gain_out
);
    typedef enum logic [0:0] {ST_IDLE, ST_CONV} acg_state_t;

    typedef struct packed {
        acg_state_t            st;
        logic [3:0][7:0]       cfg;
        logic [23:0]           cnt;
        logic [15:0]           result;
        logic [15:0]           rd;
        logic                  drdy_n;
        logic                  wr_pend;
        logic [1:0]            wr_idx;
        acg_pkg::acg_gain_t    gain;
    } acg_ctl_t;

    acg_ctl_t          st_r;
    acg_ctl_t          st_nxt;
    acg_pkg::acg_cmd_t cmd;
    logic              done;
    logic              cont;
    logic [23:0]       period;
    logic [1:0]        cmd_idx;

    acg_cmd_rx u_rx (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .scl_i    (scl_i),
        .sda_i    (sda_i),
        .sda_o    (sda_o),
        .sda_oe_n (sda_oe_n),
        .cmd      (cmd)
    );

    // Effective gain exponent after the ground-input clamp
    function automatic logic [2:0] eff_gain(input logic [7:0] r0);
        logic [2:0] g;
        logic [3:0] m;
        g = r0[acg_pkg::GAIN_LSB +: 3];
        m = r0[acg_pkg::MUX_LSB +: 4];
        if (m >= acg_pkg::MUX_GND_LO && m <= acg_pkg::MUX_GND_HI &&
            g > acg_pkg::GAIN_SC_MAX) begin
            g = acg_pkg::GAIN_SC_MAX;
        end
        return g;
    endfunction : eff_gain

    function automatic acg_pkg::acg_gain_t split(input logic [7:0] r0);
        acg_pkg::acg_gain_t o;
        logic [2:0] g;
        logic [3:0] m;
        logic       force_skip;
        g = eff_gain(r0);
        m = r0[acg_pkg::MUX_LSB +: 4];
        force_skip = (m >= acg_pkg::MUX_GND_LO) && (m <= acg_pkg::MUX_GND_HI);
        if (g > acg_pkg::GAIN_SC_MAX) begin
            o.sc_log2  = acg_pkg::GAIN_SC_MAX[1:0];
            o.amp_log2 = g - acg_pkg::GAIN_SC_MAX;
            o.amp_on   = 1'b1;
        end else begin
            o.sc_log2  = g[1:0];
            o.amp_log2 = 3'h0;
            o.amp_on   = ~(force_skip | r0[acg_pkg::SKIP_BIT]);
        end
        o.full_scale_span = acg_pkg::FSR_UV_G1 >> g;
        return o;
    endfunction : split

    // Faster rate codes halve the period; a shorter base speeds simulation
    assign period  = 24'(BASE_CYCLES) >> st_r.cfg[1][acg_pkg::RATE_LSB +: 3];
    assign cont    = st_r.cfg[1][acg_pkg::MODE_BIT];
    assign done    = (st_r.st == ST_CONV) && (st_r.cnt <= 24'h1);
    assign cmd_idx = cmd.byte_val[acg_pkg::CMD_IDX_LSB +: 2];

    always_comb begin
        st_nxt      = st_r;
        st_nxt.gain = split(st_r.cfg[0]);
        if (st_r.st == ST_CONV) begin
            st_nxt.cnt = st_r.cnt - 24'h1;
        end
        if (done) begin
            st_nxt.result = conv_data_in;
            if (cont) begin
                st_nxt.cnt = period;
            end else begin
                st_nxt.st = ST_IDLE;
            end
        end
        if (cmd.valid && st_r.wr_pend) begin
            st_nxt.cfg[st_r.wr_idx] = cmd.byte_val;
            st_nxt.wr_pend          = 1'b0;
        end else if (cmd.valid) begin
            unique case (1'b1)
                cmd.byte_val == acg_pkg::CMD_RESET: begin
                    st_nxt.cfg    = {4{acg_pkg::CFG_RST}};
                    st_nxt.st     = ST_IDLE;
                    st_nxt.drdy_n = 1'b1;
                end
                cmd.byte_val == acg_pkg::CMD_START: begin
                    st_nxt.st  = ST_CONV;
                    st_nxt.cnt = period;
                end
                cmd.byte_val == acg_pkg::CMD_POWERDOWN: begin
                    st_nxt.st = ST_IDLE;
                end
                cmd.byte_val == acg_pkg::CMD_RDATA: begin
                    // Snapshot whole word so a later update cannot tear it
                    st_nxt.rd = done ? conv_data_in : st_r.result;
                end
                (cmd.byte_val & acg_pkg::CMD_REG_MASK) == acg_pkg::CMD_RREG: begin
                    st_nxt.rd = {8'h00, st_r.cfg[cmd_idx]};
                end
                (cmd.byte_val & acg_pkg::CMD_REG_MASK) == acg_pkg::CMD_WREG: begin
                    st_nxt.wr_pend = 1'b1;
                    st_nxt.wr_idx  = cmd_idx;
                end
                default: begin
                end
            endcase
        end
        // Completion wins over the read that clears the ready flag
        if (cmd.valid && !st_r.wr_pend && cmd.byte_val == acg_pkg::CMD_RDATA) begin
            st_nxt.drdy_n = 1'b1;
        end
        if (done) begin
            st_nxt.drdy_n = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st_r <= '{st: ST_IDLE, drdy_n: 1'b1, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_data            = st_r.rd;
    assign drdy_n             = st_r.drdy_n;
    assign low_power          = (st_r.st == ST_IDLE);
    assign input_select_field = st_r.cfg[0][acg_pkg::MUX_LSB +: 4];
    assign gain_out           = st_r.gain;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_single_end;
        done && !cont && !cmd.valid;
    endsequence
    sequence s_idle_quiet;
        st_r.st == ST_IDLE ##1 st_r.st == ST_IDLE;
    endsequence

    AST_SINGLE_IDLE: assert property (s_single_end |=> low_power && !done)
        else $error("Single-shot did not return to idle");
    AST_ONE_PER_START: assert property (s_single_end ##1 !cmd.valid |=> !done)
        else $error("Extra single-shot conversion");
    AST_IDLE_NO_DONE: assert property (st_r.st == ST_IDLE |-> !done)
        else $error("Conversion completed while idle");
    AST_CONT_RESTART: assert property (done && cont && !cmd.valid |=>
        st_r.st == ST_CONV && st_r.cnt == $past(period))
        else $error("Continuous mode did not restart");
    AST_RATE_COUNT: assert property (st_r.st == ST_CONV && !done && !cmd.valid
        |=> st_r.cnt == $past(st_r.cnt) - 24'h1)
        else $error("Conversion counter off rate");
    AST_RESULT_LATEST: assert property (done |=> st_r.result == $past(conv_data_in))
        else $error("Result buffer missed a completion");
    AST_RD_STABLE: assert property (!cmd.valid |=> $stable(rd_data))
        else $error("Read word changed without a read");
    AST_DRDY_SET_WINS: assert property (done |=> !drdy_n)
        else $error("Completion lost to ready clear");
    AST_GAIN_SUM: assert property (s_idle_quiet ##0 $stable(st_r.cfg[0]) |->
        gain_out.amp_log2 + 3'(gain_out.sc_log2) == eff_gain(st_r.cfg[0]))
        else $error("Gain split does not add up");
    AST_FSR: assert property (##1 !$changed(st_r.cfg[0]) |->
        (gain_out.full_scale_span << (gain_out.amp_log2 + 3'(gain_out.sc_log2)))
        == acg_pkg::FSR_UV_G1)
        else $error("Full-scale span inconsistent with gain");
    AST_SKIP_LOW_GAIN: assert property (!gain_out.amp_on |-> gain_out.amp_log2 == 3'h0)
        else $error("Amplifier bypassed at high gain");
    AST_FORCE_BYPASS: assert property ($stable(st_r.cfg[0]) &&
        input_select_field >= acg_pkg::MUX_GND_LO &&
        input_select_field <= acg_pkg::MUX_GND_HI |-> !gain_out.amp_on)
        else $error("Ground input did not force bypass");
endmodule : acg_conv_ctrl

// *** tb/acg_host_model.sv ***
// Two-wire host model that frames command bytes for the converter.
// Assumes a pull-up on the data line and a 50 ns ref_clk for pacing.
`timescale 1ns/1ps
module acg_host_model (
    input  wire logic ref_clk,
    input  wire logic sda_line,
    output logic      scl_o,
    output logic      sda_o
);
    localparam int HALF = 8;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic pace(input int n);
        repeat (n) @(posedge ref_clk);
        #5;
    endtask : pace
    // Clock idles high between frames, so no stray edges reach the receiver
    task automatic start_cond();
        sda_o = 1'b0;
        pace(HALF);
    endtask : start_cond
    // MSB first, ninth clock leaves data released for the acknowledge
    task automatic put_byte(input logic [7:0] b, output logic ack_n);
        for (int i = 7; i >= -1; i--) begin
            scl_o = 1'b0;
            pace(HALF / 2);
            sda_o = (i < 0) ? 1'b1 : b[i];
            pace(HALF / 2);
            scl_o = 1'b1;
            pace(HALF);
            ack_n = sda_line;
        end
    endtask : put_byte
    task automatic stop_cond();
        scl_o = 1'b0;
        sda_o = 1'b0;
        pace(HALF);
        scl_o = 1'b1;
        pace(HALF);
        sda_o = 1'b1;
        pace(HALF);
    endtask : stop_cond
endmodule : acg_host_model

// *** tb/testbench.sv ***
// Self-checking bench for the converter control block.
// Assumes the host model as far side and a shortened base period.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
    $display("unexpected at %0t: got %0h exp %0h", $time, (a), (b)); end end
module testbench;
    localparam int unsigned BASE = 1024;
    localparam int LIMIT = 60000;
    logic               ref_clk, resetn, scl, sda_host, sda_o, sda_oe_n;
    logic               drdy_n, low_power, ramp;
    logic [15:0]        conv_data_in, rd_data, r1;
    logic [3:0]         input_select_field;
    acg_pkg::acg_gain_t gain_out;
    int                 error_cnt, samples_checked, cyc;
    wire                sda_line = sda_host & (sda_oe_n | sda_o);

    acg_conv_ctrl #(.BASE_CYCLES(BASE)) u_acg_conv_ctrl (
        .ref_clk(ref_clk), .resetn(resetn), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe_n(sda_oe_n), .conv_data_in(conv_data_in),
        .rd_data(rd_data), .drdy_n(drdy_n), .low_power(low_power),
        .input_select_field(input_select_field), .gain_out(gain_out));
    acg_host_model u_acg_host_model (
        .ref_clk(ref_clk), .sda_line(sda_line), .scl_o(scl), .sda_o(sda_host));

    initial ref_clk = 1'b0;
    always #25 ref_clk = ~ref_clk;
    // Ramp data makes each completion carry its own cycle stamp
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        conv_data_in <= #5 (ramp ? cyc[15:0] : 16'hA5C3);
        if (cyc == LIMIT) begin
            error_cnt++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    task automatic put(input logic [7:0] b);
        logic a;
        u_acg_host_model.put_byte(b, a);
        `CHK(a, 1'b0);
    endtask : put
    task automatic cmd(input logic [7:0] c);
        u_acg_host_model.start_cond();
        put(c);
        u_acg_host_model.stop_cond();
    endtask : cmd
    task automatic wreg(input logic [1:0] idx, input logic [7:0] v);
        u_acg_host_model.start_cond();
        put(acg_pkg::CMD_WREG | {4'h0, idx, 2'h0});
        put(v);
        u_acg_host_model.stop_cond();
    endtask : wreg
    task automatic rreg(input logic [1:0] idx, input logic [7:0] v);
        cmd(acg_pkg::CMD_RREG | {4'h0, idx, 2'h0});
        `CHK(rd_data, {8'h00, v});
    endtask : rreg
    task automatic wait_drdy(input int n);
        int k;
        k = 0;
        while (drdy_n !== 1'b0 && k < n) begin
            @(posedge ref_clk);
            #5;
            k++;
        end
        `CHK(drdy_n, 1'b0);
    endtask : wait_drdy
    // Expected split: codes are exponents, ground inputs clamp and bypass
    task automatic chk_gain(input logic [3:0] m, input logic s, input logic [2:0] g);
        logic               gnd;
        logic [2:0]         e;
        acg_pkg::acg_gain_t x;
        gnd = (m >= 4'h8) && (m <= 4'hB);
        e = (gnd && g > 3'h2) ? 3'h2 : g;
        x.amp_log2 = (e > 3'h2) ? e - 3'h2 : 3'h0;
        x.sc_log2 = (e > 3'h2) ? 2'h2 : e[1:0];
        x.amp_on = !(gnd || (s && e <= 3'h2));
        x.full_scale_span = acg_pkg::FSR_UV_G1 >> e;
        wreg(2'h0, {m, g, s});
        `CHK(gain_out, x);
        `CHK(input_select_field, m);
    endtask : chk_gain

    initial begin
        resetn = 1'b0;
        ramp = 1'b0;
        cyc = 0;
        conv_data_in = 16'h0000;
        error_cnt = 0;
        samples_checked = 0;
        repeat (16) @(posedge ref_clk);
        #5 resetn = 1'b1;
        repeat (2) @(posedge ref_clk);
        #5;
        `CHK(low_power, 1'b1);
        `CHK(drdy_n, 1'b1);
        `CHK(gain_out, {3'h0, 2'h0, 1'b1, acg_pkg::FSR_UV_G1});
        for (int s = 0; s < 2; s++)
            for (int g = 0; g < 8; g++) chk_gain(4'h0, s[0], g[2:0]);
        for (int m = 7; m < 13; m++) chk_gain(m[3:0], 1'b1, 3'h7);
        wreg(2'h2, 8'h5A);
        wreg(2'h3, 8'hC3);
        rreg(2'h2, 8'h5A);
        rreg(2'h3, 8'hC3);
        rreg(2'h0, 8'hCF);
        wreg(2'h1, 8'h00);
        cmd(acg_pkg::CMD_START);
        `CHK(low_power, 1'b0);
        wait_drdy(BASE);
        `CHK(low_power, 1'b1);
        ramp = 1'b1;
        cmd(acg_pkg::CMD_RDATA);
        `CHK(rd_data, 16'hA5C3);
        repeat (2 * BASE) @(posedge ref_clk);
        #5;
        `CHK(drdy_n, 1'b1);
        // Code 2 gives a quarter of the base period, long enough for a read
        wreg(2'h1, 8'h48);
        cmd(acg_pkg::CMD_START);
        wait_drdy(BASE / 4 + 8);
        cmd(acg_pkg::CMD_RDATA);
        r1 = rd_data;
        wait_drdy(BASE / 4 + 8);
        cmd(acg_pkg::CMD_RDATA);
        `CHK(rd_data - r1, 16'h0100);
        cmd(acg_pkg::CMD_POWERDOWN);
        `CHK(low_power, 1'b1);
        // A completion may land before the abort; clear it so only a new one shows
        cmd(acg_pkg::CMD_RDATA);
        repeat (BASE / 2) @(posedge ref_clk);
        #5;
        `CHK(drdy_n, 1'b1);
        cmd(acg_pkg::CMD_RESET);
        `CHK(gain_out, {3'h0, 2'h0, 1'b1, acg_pkg::FSR_UV_G1});
        rreg(2'h2, 8'h00);
        wrap_up();
    end
endmodule : testbench
